// File: rtl/bdmtc_pkg.sv
// constants and types of the bus dma map translation cache
// Functional notes
// - one map entry per external page, 8192
// - entries live in 32 Kbyte main memory
// - window address bits 14:2 equal page
// - valid entry maps page to page number
// - invalid entry declines the bus cycle
// - entry bits 30:20 read zero, written zero
// - aligned word access in two windows only
// - entry memory address offset from base register
// - sixteen line associative cache holds valid entries only
// - map accesses use local bus, not external
// - external masters cannot reach map entries
// - cached processor read arbitrated then answered
// - missed processor read retries, fetches, delivers
// - processor read never loads the cache
// - write latched, acknowledged, then written by DMA
// - processor write drops matching cache line
// - page boundary end prefetches next entry
// - cache replacement is first in first out
// - external miss fetches, checks valid, caches
// - processor loopback ignores access enable flag
// - access enable clear blocks external DMA
// - translated address is page plus offset
// - writes reply early, reads need memory
// - flush on reset, command, io reset, base
package bdmtc_pkg;

	localparam int MAP_ENTRIES  = 8192;
	localparam int CACHE_LINES  = 16;
	localparam int PAGE_NUM_W   = 20;
	localparam int TAG_W        = 13;
	localparam int EXT_ADDR_W   = 22;
	localparam int MEM_ADDR_W   = 29;
	localparam int BASE_W       = 14;
	localparam int PAGE_OFS_W   = 9;
	localparam int MAP_REGION_BYTES = 32768;

	localparam logic [31:0] WIN_MAIN_FIRST = 32'h10088000;
	localparam logic [31:0] WIN_MAIN_LAST  = 32'h1008FFFC;
	localparam logic [31:0] WIN_DIAG_FIRST = 32'h20088000;
	localparam logic [31:0] WIN_DIAG_LAST  = 32'h2008FFFC;

	localparam int          IDX_LO         = 2;
	localparam int          IDX_HI         = 14;
	localparam int          EXT_PAGE_LO    = 9;
	localparam int          EXT_PAGE_HI    = 21;
	localparam int          ENTRY_VALID    = 31;
	localparam logic [31:0] ENTRY_RSVD     = 32'h7FF00000;
	localparam logic [3:0]  ALL_BYTES      = 4'hF;
	localparam logic [1:0]  WORD_ALIGN     = 2'h0;
	localparam logic [8:0]  PAGE_START     = 9'h000;

	typedef struct packed {
		logic                  valid;
		logic [10:0]           zero;
		logic [PAGE_NUM_W-1:0] page;
	} bdmtc_entry_t;

	typedef struct packed {
		logic                  req;
		logic                  write;
		logic [MEM_ADDR_W-1:0] addr;
		logic [31:0]           wdata;
		logic [3:0]            byteEn;
	} bdmtc_mem_req_t;

	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_EXT_RD = 5'h02,
		ST_CPU_RD = 5'h04,
		ST_FETCH  = 5'h08,
		ST_WRITE  = 5'h10
	} bdmtc_state_t;

	typedef enum logic [2:0] {
		FK_EXT  = 3'h1,
		FK_PREF = 3'h2,
		FK_CPU  = 3'h4
	} bdmtc_fetch_t;

endpackage

// File: rtl/bdmtc_page_ram.sv
// page number store of the map cache lines, registered read
`timescale 1ns/1ps
module bdmtc_page_ram
	import bdmtc_pkg::*;
#(
	parameter int LINES  = CACHE_LINES,
	parameter int DATA_W = PAGE_NUM_W
)(
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     wrEn,
	input  wire logic [$clog2(LINES)-1:0] wrAddr,
	input  wire logic [DATA_W-1:0]        wrData,
	input  wire logic [$clog2(LINES)-1:0] rdAddr,
	output logic      [DATA_W-1:0]        rdData
);

	logic [DATA_W-1:0] store [LINES];
	logic [DATA_W-1:0] next_rdData;

	always_comb
	begin
		next_rdData = store[rdAddr];
	end

	always_ff @(posedge clk)
	begin
		if (wrEn)
		begin
			store[wrAddr] <= wrData;
		end
		if (!rst_n)
		begin
			rdData <= '0;
		end
		else
		begin
			rdData <= next_rdData;
		end
	end

endmodule

// File: rtl/bdmtc_core.sv
// map entry window, map cache and translation for external bus DMA
`timescale 1ns/1ps
module bdmtc_core
	import bdmtc_pkg::*;
#(
	parameter int LINES = CACHE_LINES
)(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  cpuReq,
	input  wire logic                  cpuWrite,
	input  wire logic [31:0]           cpuAddr,
	input  wire logic [3:0]            cpuByteEn,
	input  wire logic [31:0]           cpuWdata,
	output logic                       cpuAck,
	output logic                       cpuRetry,
	output logic      [31:0]           cpuRdata,
	input  wire logic                  extReq,
	input  wire logic                  extWrite,
	input  wire logic [EXT_ADDR_W-1:0] extAddr,
	input  wire logic                  extViaCpu,
	input  wire logic                  externalAccessEnable,
	input  wire logic                  memPresent,
	output logic                       busReply,
	output logic                       extDecline,
	output logic      [MEM_ADDR_W-1:0] xlatAddr,
	input  wire logic                  dmaEnd,
	input  wire logic [EXT_ADDR_W-1:0] dmaEndAddr,
	input  wire logic [BASE_W-1:0]     mapBase,
	input  wire logic                  mapBaseWrite,
	input  wire logic                  mapCacheInvalidateAll,
	input  wire logic                  ioBusResetRegisterWrite,
	output bdmtc_mem_req_t             localSystemBus,
	input  wire logic                  memAck,
	input  wire logic [31:0]           memRdata
);

	localparam int IDX_W = $clog2(LINES);

	bdmtc_state_t          state;
	bdmtc_state_t          next_state;
	bdmtc_fetch_t          kind;
	bdmtc_fetch_t          next_kind;
	logic [LINES-1:0]      lineValid;
	logic [LINES-1:0]      next_lineValid;
	logic [TAG_W-1:0]      tag [LINES];
	logic [TAG_W-1:0]      next_tag [LINES];
	logic [IDX_W-1:0]      fifoPtr;
	logic [IDX_W-1:0]      next_fifoPtr;
	logic [BASE_W-1:0]     baseReg;
	logic [BASE_W-1:0]     next_baseReg;
	logic [TAG_W-1:0]      pendPage;
	logic [TAG_W-1:0]      next_pendPage;
	logic [PAGE_OFS_W-1:0] extLow;
	logic [PAGE_OFS_W-1:0] next_extLow;
	logic                  extWr;
	logic                  next_extWr;
	logic                  prefPend;
	logic                  next_prefPend;
	logic [TAG_W-1:0]      prefPage;
	logic [TAG_W-1:0]      next_prefPage;
	logic                  heldValid;
	logic                  next_heldValid;
	logic [TAG_W-1:0]      heldIdx;
	logic [TAG_W-1:0]      next_heldIdx;
	logic [31:0]           heldData;
	logic [31:0]           next_heldData;
	logic                  next_cpuAck;
	logic                  next_cpuRetry;
	logic [31:0]           next_cpuRdata;
	logic                  next_busReply;
	logic                  next_extDecline;
	logic [MEM_ADDR_W-1:0] next_xlatAddr;
	bdmtc_mem_req_t        next_localSystemBus;

	logic [LINES-1:0]      extHitVec;
	logic [LINES-1:0]      cpuHitVec;
	logic [LINES-1:0]      prefHitVec;
	logic [TAG_W-1:0]      extPage;
	logic [TAG_W-1:0]      cpuIdx;
	logic                  cpuWin;
	logic                  flush;
	bdmtc_entry_t          fetched;
	logic                  ramWe;
	logic [IDX_W-1:0]      ramRAddr;
	logic [PAGE_NUM_W-1:0] ramRData;

	// lowest set bit of a hit vector as a line index
	function automatic logic [IDX_W-1:0] lineOf(input logic [LINES-1:0] vec);
		logic [IDX_W-1:0] idx;
		idx = '0;
		for (int i = LINES - 1; i >= 0; i--)
		begin
			if (vec[i])
			begin
				idx = IDX_W'(i);
			end
		end
		return idx;
	endfunction

	// main memory word address of a map entry
	function automatic logic [MEM_ADDR_W-1:0] entryAddr(input logic [BASE_W-1:0] base,
		input logic [TAG_W-1:0] page);
		return {base, page, WORD_ALIGN};
	endfunction

	assign extPage = extAddr[EXT_PAGE_HI:EXT_PAGE_LO];
	assign cpuIdx  = cpuAddr[IDX_HI:IDX_LO];
	// only the local processor port reaches the window
	assign cpuWin  = (cpuAddr[IDX_LO-1:0] == WORD_ALIGN)
		&& (((cpuAddr >= WIN_MAIN_FIRST) && (cpuAddr <= WIN_MAIN_LAST))
		|| ((cpuAddr >= WIN_DIAG_FIRST) && (cpuAddr <= WIN_DIAG_LAST)));
	assign flush   = mapBaseWrite || mapCacheInvalidateAll || ioBusResetRegisterWrite;
	assign fetched = bdmtc_entry_t'(memRdata & ~ENTRY_RSVD);

	// fully associative tag match
	genvar g;
	generate
		for (g = 0; g < LINES; g++)
		begin : gen_match
			assign extHitVec[g]  = lineValid[g] && (tag[g] == extPage);
			assign cpuHitVec[g]  = lineValid[g] && (tag[g] == cpuIdx);
			assign prefHitVec[g] = lineValid[g] && (tag[g] == prefPage);
		end
	endgenerate

	bdmtc_page_ram #(
		.LINES  (LINES),
		.DATA_W (PAGE_NUM_W)
	) u_page_ram (
		.clk    (clk),
		.rst_n  (rst_n),
		.wrEn   (ramWe),
		.wrAddr (fifoPtr),
		.wrData (fetched.page),
		.rdAddr (ramRAddr),
		.rdData (ramRData)
	);

	always_comb
	begin
		next_state          = state;
		next_kind           = kind;
		next_tag            = tag;
		next_fifoPtr        = fifoPtr;
		next_baseReg        = mapBaseWrite ? mapBase : baseReg;
		next_pendPage       = pendPage;
		next_extLow         = extLow;
		next_extWr          = extWr;
		next_prefPend       = prefPend;
		next_prefPage       = prefPage;
		next_heldIdx        = heldIdx;
		next_heldData       = heldData;
		next_cpuAck         = 1'b0;
		next_cpuRetry       = 1'b0;
		next_cpuRdata       = cpuRdata;
		next_busReply       = 1'b0;
		next_extDecline     = 1'b0;
		next_xlatAddr       = xlatAddr;
		next_localSystemBus = localSystemBus;
		ramWe               = 1'b0;
		ramRAddr            = '0;
		// flush first so that a line loaded this cycle survives
		next_lineValid      = flush ? '0 : lineValid;
		next_heldValid      = flush ? 1'b0 : heldValid;
		unique case (state)
			ST_IDLE:
			begin
				if (prefPend)
				begin
					next_prefPend = 1'b0;
					if (prefHitVec == '0)
					begin
						next_pendPage       = prefPage;
						next_kind           = FK_PREF;
						next_state          = ST_FETCH;
						next_localSystemBus = '{1'b1, 1'b0, entryAddr(baseReg, prefPage), '0,
							ALL_BYTES};
					end
				end
				else if (extReq && !busReply && !extDecline)
				begin
					next_pendPage = extPage;
					next_extLow   = extAddr[PAGE_OFS_W-1:0];
					next_extWr    = extWrite;
					if (!externalAccessEnable && !extViaCpu)
					begin
						next_extDecline = 1'b1;
					end
					else if (extHitVec != '0)
					begin
						ramRAddr   = lineOf(extHitVec);
						next_state = ST_EXT_RD;
					end
					else
					begin
						next_kind           = FK_EXT;
						next_state          = ST_FETCH;
						next_localSystemBus = '{1'b1, 1'b0, entryAddr(baseReg, extPage), '0,
							ALL_BYTES};
					end
				end
				else if (cpuReq && cpuWin && !cpuAck && !cpuRetry)
				begin
					if (cpuWrite)
					begin
						next_cpuAck         = 1'b1;
						next_state          = ST_WRITE;
						next_localSystemBus = '{1'b1, 1'b1, entryAddr(baseReg, cpuIdx),
							cpuWdata & ~ENTRY_RSVD, cpuByteEn};
						next_lineValid      = next_lineValid & ~cpuHitVec;
						if (heldIdx == cpuIdx)
						begin
							next_heldValid = 1'b0;
						end
					end
					else if (heldValid && (heldIdx == cpuIdx))
					begin
						next_cpuAck    = 1'b1;
						next_cpuRdata  = heldData;
						next_heldValid = 1'b0;
					end
					else if (cpuHitVec != '0)
					begin
						ramRAddr   = lineOf(cpuHitVec);
						next_state = ST_CPU_RD;
					end
					else
					begin
						next_cpuRetry       = 1'b1;
						next_heldIdx        = cpuIdx;
						next_kind           = FK_CPU;
						next_state          = ST_FETCH;
						next_localSystemBus = '{1'b1, 1'b0, entryAddr(baseReg, cpuIdx), '0,
							ALL_BYTES};
					end
				end
			end
			ST_EXT_RD:
			begin
				next_xlatAddr   = {ramRData, extLow};
				next_busReply   = extWr || memPresent;
				next_extDecline = !(extWr || memPresent);
				next_state      = ST_IDLE;
			end
			ST_CPU_RD:
			begin
				// a cached line was valid when loaded
				next_cpuRdata = bdmtc_entry_t'{1'b1, '0, ramRData};
				next_cpuAck   = 1'b1;
				next_state    = ST_IDLE;
			end
			ST_FETCH:
			begin
				if (memAck)
				begin
					next_localSystemBus.req = 1'b0;
					next_state              = ST_IDLE;
					unique case (kind)
						FK_CPU:
						begin
							next_heldData  = fetched;
							next_heldValid = 1'b1;
						end
						FK_EXT, FK_PREF:
						begin
							if (fetched.valid)
							begin
								ramWe                   = 1'b1;
								next_lineValid[fifoPtr] = 1'b1;
								next_tag[fifoPtr]       = pendPage;
								next_fifoPtr            = fifoPtr + IDX_W'(1);
							end
							if (kind == FK_EXT)
							begin
								next_xlatAddr   = {fetched.page, extLow};
								next_busReply   = fetched.valid && (extWr || memPresent);
								next_extDecline = !(fetched.valid && (extWr || memPresent));
							end
						end
						default:
						begin
							next_state = ST_IDLE;
						end
					endcase
				end
			end
			ST_WRITE:
			begin
				if (memAck)
				begin
					next_localSystemBus.req = 1'b0;
					next_state              = ST_IDLE;
				end
			end
			default:
			begin
				next_state = ST_IDLE;
			end
		endcase
		// a new boundary request wins over the one just taken
		if (dmaEnd && (dmaEndAddr[PAGE_OFS_W-1:0] == PAGE_START))
		begin
			next_prefPend = 1'b1;
			next_prefPage = dmaEndAddr[EXT_PAGE_HI:EXT_PAGE_LO];
		end
	end

	always_ff @(posedge clk)
	begin
		tag <= next_tag;
		if (!rst_n)
		begin
			state          <= ST_IDLE;
			kind           <= FK_EXT;
			lineValid      <= '0;
			fifoPtr        <= '0;
			baseReg        <= '0;
			pendPage       <= '0;
			extLow         <= '0;
			extWr          <= 1'b0;
			prefPend       <= 1'b0;
			prefPage       <= '0;
			heldValid      <= 1'b0;
			heldIdx        <= '0;
			heldData       <= '0;
			cpuAck         <= 1'b0;
			cpuRetry       <= 1'b0;
			cpuRdata       <= '0;
			busReply       <= 1'b0;
			extDecline     <= 1'b0;
			xlatAddr       <= '0;
			localSystemBus <= '0;
		end
		else
		begin
			state          <= next_state;
			kind           <= next_kind;
			lineValid      <= next_lineValid;
			fifoPtr        <= next_fifoPtr;
			baseReg        <= next_baseReg;
			pendPage       <= next_pendPage;
			extLow         <= next_extLow;
			extWr          <= next_extWr;
			prefPend       <= next_prefPend;
			prefPage       <= next_prefPage;
			heldValid      <= next_heldValid;
			heldIdx        <= next_heldIdx;
			heldData       <= next_heldData;
			cpuAck         <= next_cpuAck;
			cpuRetry       <= next_cpuRetry;
			cpuRdata       <= next_cpuRdata;
			busReply       <= next_busReply;
			extDecline     <= next_extDecline;
			xlatAddr       <= next_xlatAddr;
			localSystemBus <= next_localSystemBus;
		end
	end

endmodule

// File: testbench/bdmtc_checker.sv
// assertions on the map translation cache ports
`timescale 1ns/1ps
module bdmtc_checker
	import bdmtc_pkg::*;
#(
	parameter int LINES = CACHE_LINES
)(
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire logic                  cpuWrite,
	input wire logic                  cpuAck,
	input wire logic                  cpuRetry,
	input wire logic [31:0]           cpuRdata,
	input wire logic [EXT_ADDR_W-1:0] extAddr,
	input wire logic                  extViaCpu,
	input wire logic                  externalAccessEnable,
	input wire logic                  busReply,
	input wire logic                  extDecline,
	input wire logic [MEM_ADDR_W-1:0] xlatAddr,
	input wire logic [BASE_W-1:0]     mapBase,
	input wire logic                  mapBaseWrite,
	input wire bdmtc_mem_req_t        localSystemBus,
	input wire logic                  memAck
);
	logic [BASE_W-1:0] baseSeen;
	logic [BASE_W-1:0] next_baseSeen;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// base as the design should have latched it
	always_comb
	begin
		next_baseSeen = baseSeen;
		if (mapBaseWrite)
			next_baseSeen = mapBase;
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			baseSeen <= '0;
		else
			baseSeen <= next_baseSeen;
	end

	sequence s_dma_read;
		localSystemBus.req && !localSystemBus.write;
	endsequence
	sequence s_dma_write;
		localSystemBus.req && localSystemBus.write;
	endsequence

	property p_retry; cpuRetry |-> !cpuAck ##0 s_dma_read; endproperty
	a_retry: assert property (p_retry) else $error("retry without fetch");
	property p_wr_dma; cpuAck && cpuWrite |-> s_dma_write; endproperty
	a_wr_dma: assert property (p_wr_dma) else $error("write not sent");
	property p_wzero; s_dma_write |-> (localSystemBus.wdata & ENTRY_RSVD) == 32'h0; endproperty
	a_wzero: assert property (p_wzero) else $error("unused bits written");
	property p_rzero; cpuAck && !cpuWrite |-> (cpuRdata & ENTRY_RSVD) == 32'h0; endproperty
	a_rzero: assert property (p_rzero) else $error("unused bits read");
	property p_base; localSystemBus.req |-> localSystemBus.addr[28:15] == baseSeen; endproperty
	a_base: assert property (p_base) else $error("entry address off base");
	property p_align; localSystemBus.req |-> localSystemBus.addr[1:0] == WORD_ALIGN; endproperty
	a_align: assert property (p_align) else $error("entry address unaligned");
	property p_offset; busReply |-> xlatAddr[8:0] == extAddr[8:0]; endproperty
	a_offset: assert property (p_offset) else $error("page offset changed");
	property p_enable; busReply && !extViaCpu |-> externalAccessEnable; endproperty
	a_enable: assert property (p_enable) else $error("reply while disabled");
	property p_hold;
		localSystemBus.req && !memAck |=> localSystemBus.req && $stable(localSystemBus.addr);
	endproperty
	a_hold: assert property (p_hold) else $error("memory request dropped");
	property p_answer; busReply |-> !extDecline ##1 !busReply; endproperty
	a_answer: assert property (p_answer) else $error("double answer");
endmodule

bind bdmtc_core bdmtc_checker #(.LINES(LINES)) bdmtc_checker_i (.clk, .rst_n, .cpuWrite, .cpuAck,
	.cpuRetry, .cpuRdata, .extAddr, .extViaCpu, .externalAccessEnable, .busReply, .extDecline,
	.xlatAddr, .mapBase, .mapBaseWrite, .localSystemBus, .memAck);

// File: testbench/bdmtc_mem_model.sv
// behavioural main memory holding the page map region
`timescale 1ns/1ps
module bdmtc_mem_model
	import bdmtc_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire bdmtc_mem_req_t localSystemBus,
	input  wire logic [3:0]     waitCycles,
	output logic                memAck,
	output logic [31:0]         memRdata
);
	logic [31:0] mem [0:MAP_ENTRIES-1];
	logic [3:0]  cnt;
	logic [12:0] idx;
	int          nReads;

	assign idx = localSystemBus.addr[IDX_HI:IDX_LO];
	always @(posedge clk)
	begin
		memAck <= 1'b0;
		// read data is meaningless outside the acknowledge
		memRdata <= ~memRdata;
		if (!rst_n)
		begin
			cnt <= 4'h0;
			memRdata <= 32'h0;
		end
		else if (localSystemBus.req && !memAck && cnt != waitCycles)
			cnt <= cnt + 4'h1;
		else if (localSystemBus.req && !memAck)
		begin
			cnt <= 4'h0;
			memAck <= 1'b1;
			if (!localSystemBus.write)
			begin
				memRdata <= mem[idx];
				nReads <= nReads + 1;
			end
			for (int b = 0; b < 4; b++)
				if (localSystemBus.write && localSystemBus.byteEn[b])
					mem[idx][8*b +: 8] <= localSystemBus.wdata[8*b +: 8];
		end
	end
endmodule

// File: testbench/tb.sv
// bench of the map translation cache with its memory model
`timescale 1ns/1ps
module tb
	import bdmtc_pkg::*;
;
	logic                  clk, rst_n, cpuReq, cpuWrite, extReq, extWrite, extViaCpu;
	logic                  externalAccessEnable, memPresent, dmaEnd, mapBaseWrite;
	logic                  mapCacheInvalidateAll, ioBusResetRegisterWrite, memAck;
	logic                  cpuAck, cpuRetry, busReply, extDecline;
	logic [3:0]            cpuByteEn, waitCycles;
	logic [31:0]           cpuAddr, cpuWdata, cpuRdata, memRdata;
	logic [EXT_ADDR_W-1:0] extAddr, dmaEndAddr;
	logic [MEM_ADDR_W-1:0] xlatAddr;
	logic [BASE_W-1:0]     mapBase;
	bdmtc_mem_req_t        localSystemBus;
	int                    nErrors, testsRun;

	bdmtc_core #(.LINES(16)) bdmtc_core_i (.clk, .rst_n, .cpuReq, .cpuWrite, .cpuAddr, .cpuByteEn,
		.cpuWdata, .cpuAck, .cpuRetry, .cpuRdata, .extReq, .extWrite, .extAddr, .extViaCpu,
		.externalAccessEnable, .memPresent, .busReply, .extDecline, .xlatAddr, .dmaEnd,
		.dmaEndAddr, .mapBase, .mapBaseWrite, .mapCacheInvalidateAll, .ioBusResetRegisterWrite,
		.localSystemBus, .memAck, .memRdata);
	bdmtc_mem_model bdmtc_mem_model_i (.clk, .rst_n, .localSystemBus, .waitCycles, .memAck,
		.memRdata);

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cpu(input logic wr, input logic [31:0] a, d, output logic [31:0] q,
		output logic rt);
		int n;
		@(posedge clk);
		cpuReq <= 1'b1;
		cpuWrite <= wr;
		cpuAddr <= a;
		cpuWdata <= d;
		@(posedge clk);
		for (n = 0; n < 60 && cpuAck !== 1'b1 && cpuRetry !== 1'b1; n++)
			@(posedge clk);
		check(32'(cpuAck | cpuRetry), 32'h1);
		q = cpuRdata;
		rt = cpuRetry;
		cpuReq <= 1'b0;
	endtask

	// external translation request, answer and memory fetch count judged here
	task automatic xl(input logic wr, via, input logic [12:0] p, input logic [8:0] o,
		input logic [1:0] expAns, input int dr);
		int          n, r0;
		logic [31:0] e;
		r0 = bdmtc_mem_model_i.nReads;
		@(posedge clk);
		extReq <= 1'b1;
		extWrite <= wr;
		extViaCpu <= via;
		extAddr <= {p, o};
		@(posedge clk);
		for (n = 0; n < 60 && busReply !== 1'b1 && extDecline !== 1'b1; n++)
			@(posedge clk);
		e = bdmtc_mem_model_i.mem[p];
		check(32'({busReply, extDecline}), 32'(expAns));
		if (expAns == 2'h2)
			check(32'(xlatAddr), 32'({e[19:0], o}));
		check(bdmtc_mem_model_i.nReads - r0, dr);
		extReq <= 1'b0;
	endtask

	task automatic wait_idle;
		repeat (3) @(posedge clk);
		for (int n = 0; n < 60 && localSystemBus.req !== 1'b0; n++)
			@(posedge clk);
		@(posedge clk);
	endtask

	task automatic flush(input int k);
		@(posedge clk);
		mapCacheInvalidateAll <= (k == 0);
		ioBusResetRegisterWrite <= (k == 1);
		mapBaseWrite <= (k == 2);
		rst_n <= (k != 3);
		@(posedge clk);
		mapCacheInvalidateAll <= 1'b0;
		ioBusResetRegisterWrite <= 1'b0;
		mapBaseWrite <= 1'b0;
		rst_n <= 1'b1;
	endtask

	task automatic t_write;
		logic [31:0] q;
		logic        rt;
		waitCycles <= 4'h3;
		cpu(1'b1, WIN_DIAG_FIRST | 32'h48C, 32'hFFF12345, q, rt);
		check(32'(rt), 32'h0);
		// masked write keeps byte 0 of the old entry
		cpuByteEn <= 4'hE;
		cpu(1'b1, WIN_MAIN_FIRST | 32'h14, 32'h00000777, q, rt);
		cpuByteEn <= ALL_BYTES;
		wait_idle;
		check(bdmtc_mem_model_i.mem[13'h123], 32'h80012345);
		check(bdmtc_mem_model_i.mem[13'h5], 32'h00000705);
	endtask

	task automatic t_read;
		logic [31:0] q;
		logic        rt;
		cpu(1'b0, WIN_MAIN_LAST, 32'h0, q, rt);
		check(32'(rt), 32'h1);
		wait_idle;
		cpu(1'b0, WIN_MAIN_LAST, 32'h0, q, rt);
		check(q, bdmtc_mem_model_i.mem[13'h1FFF]);
		xl(1'b0, 1'b0, 13'h1FFF, 9'h1FF, 2'h2, 1);
		xl(1'b0, 1'b0, 13'h1FFF, 9'h000, 2'h2, 0);
		xl(1'b0, 1'b0, 13'h2, 9'h0A5, 2'h2, 1);
		// processor hit read and external hit on the same edge
		fork
			cpu(1'b0, WIN_DIAG_FIRST | 32'h8, 32'h0, q, rt);
			xl(1'b0, 1'b0, 13'h2, 9'h0A5, 2'h2, 0);
		join
		check(q, bdmtc_mem_model_i.mem[13'h2]);
		cpu(1'b1, WIN_MAIN_FIRST | 32'h8, 32'h80054321, q, rt);
		wait_idle;
		xl(1'b0, 1'b0, 13'h2, 9'h001, 2'h2, 1);
		xl(1'b0, 1'b0, 13'h5, 9'h001, 2'h1, 1);
		xl(1'b0, 1'b0, 13'h5, 9'h001, 2'h1, 1);
	endtask

	task automatic t_enable;
		externalAccessEnable <= 1'b0;
		xl(1'b0, 1'b0, 13'h2, 9'h010, 2'h1, 0);
		xl(1'b0, 1'b1, 13'h2, 9'h010, 2'h2, 0);
		externalAccessEnable <= 1'b1;
		memPresent <= 1'b0;
		xl(1'b0, 1'b0, 13'h2, 9'h010, 2'h1, 0);
		xl(1'b1, 1'b0, 13'h2, 9'h010, 2'h2, 0);
		memPresent <= 1'b1;
	endtask

	task automatic t_flush;
		for (int k = 0; k < 4; k++)
		begin
			flush(k);
			xl(1'b0, 1'b0, 13'h2, 9'h000, 2'h2, 1);
			xl(1'b0, 1'b0, 13'h2, 9'h000, 2'h2, 0);
		end
	endtask

	task automatic t_fifo;
		waitCycles <= 4'h0;
		flush(0);
		for (int i = 0; i < 17; i++)
			xl(1'b0, 1'b0, 13'(13'h100 + i), 9'h000, 2'h2, 1);
		xl(1'b0, 1'b0, 13'h101, 9'h000, 2'h2, 0);
		xl(1'b0, 1'b0, 13'h100, 9'h000, 2'h2, 1);
		xl(1'b0, 1'b0, 13'h101, 9'h000, 2'h2, 1);
	endtask

	task automatic t_prefetch;
		int r0;
		flush(0);
		for (int k = 0; k < 2; k++)
		begin
			r0 = bdmtc_mem_model_i.nReads;
			@(posedge clk);
			dmaEnd <= 1'b1;
			dmaEndAddr <= {13'(13'h200 + k), 9'(4 * k)};
			@(posedge clk);
			dmaEnd <= 1'b0;
			wait_idle;
			check(bdmtc_mem_model_i.nReads - r0, 32'(1 - k));
			xl(1'b0, 1'b0, 13'(13'h200 + k), 9'h000, 2'h2, k);
		end
	endtask

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial
	begin
		#(5000 * 100);
		nErrors++;
		tally_and_finish;
	end

	initial
	begin
		rst_n = 1'b0;
		{cpuReq, cpuWrite, extReq, extWrite, extViaCpu, dmaEnd, mapBaseWrite} = 7'h0;
		{mapCacheInvalidateAll, ioBusResetRegisterWrite} = 2'h0;
		{externalAccessEnable, memPresent} = 2'h3;
		cpuByteEn = ALL_BYTES;
		waitCycles = 4'h1;
		{cpuAddr, cpuWdata} = 64'h0;
		{extAddr, dmaEndAddr} = 44'h0;
		mapBase = 14'h0ABC;
		for (int i = 0; i < MAP_ENTRIES; i++)
			bdmtc_mem_model_i.mem[i] = 32'h80000100 + 32'(i);
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		check(32'({cpuAck, cpuRetry, busReply, extDecline, localSystemBus.req}), 32'h0);
		check(cpuRdata, 32'h0);
		check(32'(xlatAddr), 32'h0);
		t_write;
		t_read;
		t_enable;
		t_flush;
		t_fifo;
		t_prefetch;
		tally_and_finish;
	end
endmodule
